// ### verification/spi_master_model.sv
// Serial bus master model for the converter latch
module spi_master_model (
  input  wire logic clock_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out  = 1'b0;
  end
  // Four system clocks a half period, well under the top rate
  task automatic half_period();
    repeat (4) @(negedge clock_in);
  endtask
  // Any bit count up to 32, so short and long frames can be made
  task automatic send(input logic [31:0] word, input int nbits);
    cs_n_out = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi_out = word[i];
      half_period();
      sclk_out = 1'b1;
      half_period();
      sclk_out = 1'b0;
    end
    sdi_out = ~word[0];
    half_period();
    cs_n_out = 1'b1;
    repeat (8) @(negedge clock_in);
  endtask
  // Clock and data toggle with chip select high
  task automatic wiggle(input int n);
    for (int i = 0; i < n; i++) begin
      sdi_out  = ~sdi_out;
      sclk_out = ~sclk_out;
      half_period();
    end
  endtask
endmodule  // spi_master_model

// ### verification/tb_serial_dac_input_latch.sv
// Self-checking bench for the serial converter latch
module tb_serial_dac_input_latch;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sel = 1'b0;
  logic        load_n = 1'b0;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic [15:0] latch_code;
  logic [15:0] input_reg;
  logic        frame_err;
  int          err_total = 0;
  int          tests_run = 0;
  always #20 clk = ~clk;
  spi_master_model partner (.clock_in(clk), .cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi));
  dac_latch uut (
    .clock_in(clk), .nrst_in(rst_n), .reset_level_select_in(sel), .cs_n_in(cs_n),
    .sclk_in(sclk), .sdi_in(sdi), .latch_load_n_in(load_n), .latch_code_out(latch_code),
    .input_reg_out(input_reg), .frame_error_out(frame_err));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Strap set well before release, as the synchroniser needs
  task automatic t_reset(input logic s);
    logic [15:0] exp;
    exp = s ? dac_latch_pkg::MID_CODE : dac_latch_pkg::ZERO_CODE;
    @(negedge clk);
    rst_n = 1'b0;
    sel   = s;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check("latch after reset", latch_code, exp);
    check("input reg after reset", input_reg, exp);
  endtask
  task automatic t_tied();
    load_n = 1'b0;
    partner.send(32'h0000_a5c3, 16);
    check("input reg", input_reg, 16'ha5c3);
    check("latch tied load", latch_code, 16'ha5c3);
    check("frame error", {15'h0000, frame_err}, 16'h0000);
  endtask
  task automatic t_extra();
    partner.send(32'h000f_1234, 20);
    check("last sixteen", input_reg, 16'h1234);
  endtask
  task automatic t_short();
    partner.send(32'h0000_03ff, 10);
    check("short frame flag", {15'h0000, frame_err}, 16'h0001);
    check("short frame kept", input_reg, 16'h1234);
    partner.send(32'h0000_0001, 16);
    check("good frame clears", {15'h0000, frame_err}, 16'h0000);
  endtask
  task automatic t_ignore();
    partner.wiggle(40);
    repeat (8) @(negedge clk);
    check("idle input reg", input_reg, 16'h0001);
    check("idle latch", latch_code, 16'h0001);
  endtask
  // Load held high in the frame, driven low and left low after chip select rises
  task automatic t_load();
    load_n = 1'b1;
    partner.send(32'h0000_3c5a, 16);
    check("input reg held load", input_reg, 16'h3c5a);
    check("latch held", latch_code, 16'h0001);
    load_n = 1'b0;
    repeat (4) @(negedge clk);
    check("latch loaded", latch_code, 16'h3c5a);
  endtask
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
  initial begin
    t_reset(1'b0);
    t_tied();
    t_extra();
    t_short();
    t_ignore();
    t_load();
    t_reset(1'b1);
    t_tied();
    t_reset(1'b0);
    complete_run();
  end
endmodule  // tb_serial_dac_input_latch

// ### verilog/dac_latch.sv
// Serial input, input register and converter latch of the converter
// Function
// - 16-bit latch code alone sets output
// - Serial clock up to 50 MHz; here pins are sampled by the 25 MHz clock, so it must stay well under that
// - Select high resets latch to mid-scale
// - Select low resets latch to zero
// - Active-low hardware reset restores latches
// - Shift only while chip select low
// - Sample data on serial clock rising edge
// - Load low copies input register to latch
// - MSB first; chip select rise moves word
// - Sixteen clocks; extra keep last sixteen
// - Load tied low updates on chip-select rise
// - Reset sets input register and latch alike
module dac_latch (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        reset_level_select_in,
  input  wire logic        cs_n_in,
  input  wire logic        sclk_in,
  input  wire logic        sdi_in,
  input  wire logic        latch_load_n_in,
  output logic [15:0]      latch_code_out,
  output logic [15:0]      input_reg_out,
  output logic             frame_error_out
);
  // Pins pass two flops; link clock must stay well under this rate
  logic        cs_act_s;
  logic        cs_n_s;
  logic        sclk_s;
  logic        sdi_s;
  logic        ldn_s;
  logic        sel_s;
  logic        sclk_d_r;
  logic        sclk_d_nxt;
  logic        cs_d_r;
  logic        cs_d_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic [4:0]  cnt_r;
  logic [4:0]  cnt_nxt;
  logic [4:0]  cnt_base;
  logic [15:0] in_r;
  logic [15:0] in_nxt;
  logic [15:0] lat_r;
  logic [15:0] lat_nxt;
  logic        err_r;
  logic        err_nxt;
  logic [1:0]  boot_r;
  logic [1:0]  boot_nxt;
  logic        started_r;
  logic        started_nxt;
  logic        sclk_rise;
  logic        cs_rise;
  logic        cs_fall;
  logic        bit_take;
  logic [15:0] rst_code;

  word_if wr_ch ();
  word_if rd_ch ();

  // Chip select synchronised active high, so reset reads as deselected
  sync2 u_cs (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .d_in     (!cs_n_in),
    .q_out    (cs_act_s)
  );

  sync2 u_sclk (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .d_in     (sclk_in),
    .q_out    (sclk_s)
  );

  sync2 u_sdi (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .d_in     (sdi_in),
    .q_out    (sdi_s)
  );

  sync2 u_ldn (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .d_in     (latch_load_n_in),
    .q_out    (ldn_s)
  );

  sync2 u_sel (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .d_in     (reset_level_select_in),
    .q_out    (sel_s)
  );

  // Completed frames queue as words; valid ignores ready, so a word arriving at a full buffer is lost
  word_buf u_buf (
    .clock_in (clock_in),
    .nrst_in  (nrst_in),
    .wr       (wr_ch),
    .rd       (rd_ch)
  );

  // Strap reads zero under reset, so it is trusted only after boot
  assign rst_code = sel_s ? dac_latch_pkg::MID_CODE : dac_latch_pkg::ZERO_CODE;

  assign cs_n_s    = !cs_act_s;
  assign sclk_rise = sclk_s && !sclk_d_r;
  assign cs_rise   = cs_n_s && !cs_d_r;
  assign cs_fall   = !cs_n_s && cs_d_r;
  assign bit_take  = !cs_n_s && sclk_rise;

  assign wr_ch.data  = shift_r;
  assign wr_ch.valid = cs_rise && (cnt_r == dac_latch_pkg::FRAME_BITS);
  assign rd_ch.ready = 1'b1;

  // Edge detectors idle at the pins' idle levels
  always_comb begin
    sclk_d_nxt = sclk_s;
    cs_d_nxt   = cs_n_s;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
    end else begin
      sclk_d_r <= sclk_d_nxt;
      cs_d_r   <= cs_d_nxt;
    end
  end

  // Frame start clears the count even if a bit lands with it
  always_comb begin
    cnt_base  = cs_fall ? 5'h00 : cnt_r;
    shift_nxt = shift_r;
    cnt_nxt   = cnt_base;
    err_nxt   = err_r;
    if (bit_take) begin
      shift_nxt = {shift_r[14:0], sdi_s};
      if (cnt_base != dac_latch_pkg::FRAME_BITS) begin
        cnt_nxt = cnt_base + 5'h01;
      end
    end
    if (cs_rise) begin
      // Short frame keeps old word and flags it
      err_nxt = (cnt_r != dac_latch_pkg::FRAME_BITS);
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_r <= 16'h0000;
      cnt_r   <= 5'h00;
      err_r   <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r   <= cnt_nxt;
      err_r   <= err_nxt;
    end
  end

  // Strap needs two edges through its flops before it is trusted
  always_comb begin
    boot_nxt    = boot_r;
    started_nxt = started_r;
    if (!started_r) begin
      boot_nxt    = boot_r + 2'h1;
      started_nxt = (boot_r == dac_latch_pkg::BOOT_LAST);
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      boot_r    <= 2'h0;
      started_r <= 1'b0;
    end else begin
      boot_r    <= boot_nxt;
      started_r <= started_nxt;
    end
  end

  // Input register and converter latch
  always_comb begin
    in_nxt  = in_r;
    lat_nxt = lat_r;
    if (rd_ch.valid) begin
      in_nxt = rd_ch.data;
    end
    if (!ldn_s) begin
      lat_nxt = in_r;
    end
    if (!started_r) begin
      // Reset code reloads until the strap has settled
      in_nxt  = rst_code;
      lat_nxt = rst_code;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_r  <= 16'h0000;
      lat_r <= 16'h0000;
    end else begin
      in_r  <= in_nxt;
      lat_r <= lat_nxt;
    end
  end

  assign latch_code_out  = lat_r;
  assign input_reg_out   = in_r;
  assign frame_error_out = err_r;

  a_shift_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cs_n_s && cs_d_r |=> $stable(shift_r))
    else $error("shift moved with chip select high");
  a_shift_bit: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !cs_n_s && sclk_rise |=> shift_r[0] == $past(sdi_s))
    else $error("bit not sampled on rising edge");
  a_load_copy: assert property (@(posedge clock_in) disable iff (!nrst_in)
    started_r && !ldn_s |=> lat_r == $past(in_r))
    else $error("latch not loaded from input register");
  a_latch_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
    started_r && ldn_s |=> $stable(lat_r))
    else $error("latch changed without load");
  a_frame_word: assert property (@(posedge clock_in) disable iff (!nrst_in)
    wr_ch.valid |-> ##2 in_r == $past(shift_r, 2))
    else $error("frame word not moved to input register");
  a_short_frame: assert property (@(posedge clock_in) disable iff (!nrst_in)
    started_r && cs_rise && cnt_r != 5'h10 |=> err_r ##1 $stable(in_r))
    else $error("short frame not rejected");
  a_tied_load: assert property (@(posedge clock_in) disable iff (!nrst_in)
    started_r && wr_ch.valid && !ldn_s ##1 !ldn_s ##1 !ldn_s |=> lat_r == in_r)
    else $error("latch not updated after chip select rise");
  a_reset_mid: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !started_r && sel_s |=> lat_r == 16'h8000 && in_r == 16'h8000)
    else $error("mid-scale reset wrong");
  a_reset_zero: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !started_r && !sel_s |=> lat_r == 16'h0000 && in_r == 16'h0000)
    else $error("zero reset wrong");
  a_reset_both: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !started_r |=> lat_r == in_r)
    else $error("reset left latches unequal");
  a_reset_sel: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !started_r |=> in_r == $past(rst_code))
    else $error("input register reset wrong");
  a_mid_code: assert property (@(posedge clock_in) disable iff (!nrst_in)
    sel_s |-> rst_code == 16'h8000)
    else $error("mid-scale code wrong");

  a_err_clear: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cs_rise && cnt_r == dac_latch_pkg::FRAME_BITS |=> !err_r)
    else $error("good frame left error flag set");
  a_err_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
    !cs_rise |=> $stable(err_r))
    else $error("error flag moved without chip select rise");
  a_count_sat: assert property (@(posedge clock_in) disable iff (!nrst_in)
    cnt_r <= dac_latch_pkg::FRAME_BITS)
    else $error("bit count passed frame length");
  a_input_hold: assert property (@(posedge clock_in) disable iff (!nrst_in)
    started_r && !rd_ch.valid |=> $stable(in_r))
    else $error("input register moved without a word");

  c_good_frame: cover property (@(posedge clock_in) disable iff (!nrst_in) wr_ch.valid);
  c_long_frame: cover property (@(posedge clock_in) disable iff (!nrst_in)
    bit_take && cnt_r == dac_latch_pkg::FRAME_BITS);
  c_mid_reset: cover property (@(posedge clock_in) disable iff (!nrst_in)
    !started_r && sel_s);
  c_short_frame: cover property (@(posedge clock_in) disable iff (!nrst_in)
    cs_rise && cnt_r != 5'h10);
  c_load: cover property (@(posedge clock_in) disable iff (!nrst_in)
    started_r && !ldn_s && lat_r != in_r);
endmodule // dac_latch

// ### verilog/dac_latch_pkg.sv
// Constants shared by the serial converter latch design
package dac_latch_pkg;
  localparam int          CODE_W     = 16;
  localparam int          CNT_W      = 5;
  localparam logic [15:0] ZERO_CODE  = 16'h0000;
  localparam logic [15:0] MID_CODE   = 16'h8000;
  localparam int          CLK_MHZ    = 25;
  localparam int          SCLK_MAX_MHZ = 50;
  localparam int          BUF_DEPTH  = 2;
  localparam logic [4:0]  FRAME_BITS = 5'h10;
  localparam logic [1:0]  BOOT_LAST  = 2'h2;
endpackage

// ### verilog/sync2.sv
// Two-flop synchroniser for one pin
module sync2 (
  input  wire logic clock_in,
  input  wire logic nrst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_r;
  logic meta_nxt;
  logic q_nxt;

  always_comb begin
    meta_nxt = d_in;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      q_out  <= q_nxt;
    end
  end
endmodule // sync2

// ### verilog/word_buf.sv
// Two-entry word buffer with valid and ready on both sides
module word_buf (
  input  wire logic clock_in,
  input  wire logic nrst_in,
  word_if.dst       wr,
  word_if.src       rd
);
  logic [15:0] mem_r [2];
  logic [15:0] mem_nxt [2];
  logic        wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic        push, pop;

  assign wr.ready = (cnt_r != 2'h2);
  assign rd.valid = (cnt_r != 2'h0);
  assign rd.data  = mem_r[rp_r];

  always_comb begin
    push    = wr.valid && wr.ready;
    pop     = rd.valid && rd.ready;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wp_r] = wr.data;
    end
    wp_nxt  = push ? ~wp_r : wp_r;
    rp_nxt  = pop ? ~rp_r : rp_r;
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_r[0] <= 16'h0000;
      mem_r[1] <= 16'h0000;
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule // word_buf

// ### verilog/word_if.sv
// Valid/ready word channel between the design's modules
interface word_if;
  logic [15:0] data;
  logic        valid;
  logic        ready;
  modport src (output data, output valid, input ready);
  modport dst (input data, input valid, output ready);
endinterface
